// ---- rtl/pbsc_map.vh ----
// constants and behaviour notes for the pipelined burst sram control block
// Notes on behaviour
// - accesses are accepted only eight clock cycles after the reset pin rises.
// - read strobes toggle in step with each output word, mid data window; here they flip on the same edge that launches the word.
// - after a read burst both strobe lanes are released to high impedance.
// - a burst write captures its address only on the first clock edge.
// - write words are taken one per edge on the edges after the address.
// - write pin high during a write burst blocks the trailing one to three beats.
// - with the clock stopped all state and data are held statically.
// - clock may restart with the burst start strobe and stop after the last word.
`ifndef PBSC_MAP_VH
`define PBSC_MAP_VH
`define PBSC_RST_WAIT_CYCLES 4'h8
`define PBSC_BURST_LAST      2'h3
`define PBSC_DATA_W          36
`define PBSC_ADDR_W          16
`define PBSC_FIFO_DEPTH      8
`define PBSC_LANE_SPLIT      18
`endif

// ---- rtl/pbsc_sram_ctrl.v ----
// burst write fifo and the pipelined burst sram control core
`timescale 1ns/1ps
`include "pbsc_map.vh"

module pbsc_fifo #(
  parameter WIDTH = 52,
  parameter DEPTH = `PBSC_FIFO_DEPTH
) (
  // clock and reset
  input  wire             clock_i,
  input  wire             srst_i,
  // filling side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // draining side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  localparam PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  reg [WIDTH-1:0] store_ff [0:DEPTH-1];
  reg [PW-1:0]    wr_ptr_ff;
  reg [PW-1:0]    rd_ptr_ff;
  reg [PW:0]      count_ff;
  wire            push;
  wire            pop;

  function [PW-1:0] ptr_inc;
    input [PW-1:0] p;
    begin
      if (p == DEPTH[PW-1:0] - {{(PW-1){1'b0}}, 1'b1})
        ptr_inc = {PW{1'b0}};
      else
        ptr_inc = p + {{(PW-1){1'b0}}, 1'b1};
    end
  endfunction

  // full when the count reaches depth; beats offered then are lost
  assign in_ready_o  = (count_ff != DEPTH[PW:0]);
  assign out_valid_o = (count_ff != {(PW+1){1'b0}});
  assign out_data_o  = store_ff[rd_ptr_ff];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clock_i) begin
    if (push)
      store_ff[wr_ptr_ff] <= in_data_i;
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      wr_ptr_ff <= {PW{1'b0}};
      rd_ptr_ff <= {PW{1'b0}};
      count_ff  <= {(PW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      if (pop)
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      if (push & ~pop)
        count_ff <= count_ff + {{PW{1'b0}}, 1'b1};
      else if (pop & ~push)
        count_ff <= count_ff - {{PW{1'b0}}, 1'b1};
    end
  end
endmodule // pbsc_fifo

module pbsc_sram_ctrl #(
  parameter DATA_W     = `PBSC_DATA_W,
  parameter ADDR_W     = `PBSC_ADDR_W,
  parameter FIFO_DEPTH = `PBSC_FIFO_DEPTH
) (
  // clock and reset
  input  wire              clock_i,
  input  wire              srst_i,
  // bus pins from the controller
  input  wire              reset_n_i,
  input  wire              burst_start_strobe_n_i,
  input  wire              chip_enable_n_i,
  input  wire              write_n_i,
  input  wire [ADDR_W-1:0] sync_address_in_i,
  // data pins
  input  wire [DATA_W-1:0] dq_i,
  output reg  [DATA_W-1:0] dq_o,
  output reg               dq_oe_o,
  // data strobe lanes
  output reg               lane_a_data_strobe_o,
  output reg               lane_a_data_strobe_oe_o,
  output reg               lane_b_data_strobe_o,
  output reg               lane_b_data_strobe_oe_o,
  // status
  output reg               init_done_o,
  output reg               write_buf_ready_o
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_WRITE = 2'h1;
  localparam ST_READ  = 2'h2;
  localparam FW       = ADDR_W + DATA_W;

  // two-stage input synchronisers, stage one read only by stage two
  reg              rst_n_m_ff, rst_n_s_ff;
  reg              ads_n_m_ff, ads_n_s_ff;
  reg              ce_n_m_ff,  ce_n_s_ff;
  reg              w_n_m_ff,   w_n_s_ff;
  reg [ADDR_W-1:0] addr_m_ff,  addr_s_ff;
  reg [DATA_W-1:0] dq_m_ff,    dq_s_ff;

  reg [1:0]        state_ff;
  reg [3:0]        wait_cnt_ff;
  reg [ADDR_W-1:0] base_addr_ff;
  reg [1:0]        beat_ff;
  reg              block_ff;
  reg              rd_vld_ff;
  reg [DATA_W-1:0] rd_data_ff;
  reg [DATA_W-1:0] mem_ff [0:(1<<ADDR_W)-1];

  wire              start;
  wire [ADDR_W-1:0] beat_addr;
  wire              blocked_now;
  wire              wr_push;
  wire              fifo_in_ready;
  wire              fifo_out_valid;
  wire [FW-1:0]     fifo_out_data;
  wire              drain_ready;
  wire              rd_issue;

  // end of a four-beat burst, shared by the read and write paths
  function is_last_beat;
    input [1:0] b;
    begin
      is_last_beat = (b == `PBSC_BURST_LAST);
    end
  endfunction

  // beat step; two bits, so the count wraps inside the burst
  function [1:0] step_beat;
    input [1:0] b;
    begin
      step_beat = b + 2'h1;
    end
  endfunction

  always @(posedge clock_i) begin
    if (srst_i) begin
      rst_n_m_ff <= 1'b0;
      rst_n_s_ff <= 1'b0;
      ads_n_m_ff <= 1'b1;
      ads_n_s_ff <= 1'b1;
      ce_n_m_ff  <= 1'b1;
      ce_n_s_ff  <= 1'b1;
      w_n_m_ff   <= 1'b1;
      w_n_s_ff   <= 1'b1;
      addr_m_ff  <= {ADDR_W{1'b0}};
      addr_s_ff  <= {ADDR_W{1'b0}};
      dq_m_ff    <= {DATA_W{1'b0}};
      dq_s_ff    <= {DATA_W{1'b0}};
    end else begin
      rst_n_m_ff <= reset_n_i;
      rst_n_s_ff <= rst_n_m_ff;
      ads_n_m_ff <= burst_start_strobe_n_i;
      ads_n_s_ff <= ads_n_m_ff;
      ce_n_m_ff  <= chip_enable_n_i;
      ce_n_s_ff  <= ce_n_m_ff;
      w_n_m_ff   <= write_n_i;
      w_n_s_ff   <= w_n_m_ff;
      addr_m_ff  <= sync_address_in_i;
      addr_s_ff  <= addr_m_ff;
      dq_m_ff    <= dq_i;
      dq_s_ff    <= dq_m_ff;
    end
  end

  // pin reset held low keeps the logic quiet; release starts the wait
  always @(posedge clock_i) begin
    if (srst_i) begin
      wait_cnt_ff <= 4'h0;
      init_done_o <= 1'b0;
    end else if (!rst_n_s_ff) begin
      wait_cnt_ff <= 4'h0;
      init_done_o <= 1'b0;
    end else if (wait_cnt_ff != `PBSC_RST_WAIT_CYCLES) begin
      wait_cnt_ff <= wait_cnt_ff + 4'h1;
      init_done_o <= (wait_cnt_ff == `PBSC_RST_WAIT_CYCLES - 4'h1);
    end
  end

  // a start is only seen in idle, so one idle clock edge is needed between bursts
  assign start = init_done_o & ~ads_n_s_ff & ~ce_n_s_ff
               & (state_ff == ST_IDLE);

  // low two bits step through the burst and wrap inside it
  assign beat_addr = {base_addr_ff[ADDR_W-1:2],
                      base_addr_ff[1:0] + beat_ff};

  // a high write pin blocks this beat and every later one
  assign blocked_now = block_ff | w_n_s_ff;
  assign wr_push     = (state_ff == ST_WRITE) & ~blocked_now;

  // reads own the array port; queued writes wait, so the buffer can fill
  assign rd_issue    = (state_ff == ST_READ);
  assign drain_ready = ~rd_issue;

  always @(posedge clock_i) begin
    if (srst_i) begin
      state_ff     <= ST_IDLE;
      base_addr_ff <= {ADDR_W{1'b0}};
      beat_ff      <= 2'h0;
      block_ff     <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          beat_ff  <= 2'h0;
          block_ff <= 1'b0;
          if (start) begin
            base_addr_ff <= addr_s_ff;
            state_ff     <= w_n_s_ff ? ST_READ : ST_WRITE;
          end
        end
        ST_WRITE: begin
          block_ff <= blocked_now;
          beat_ff  <= step_beat(beat_ff);
          // back to idle forces a gap before the next start
          if (is_last_beat(beat_ff))
            state_ff <= ST_IDLE;
        end
        ST_READ: begin
          beat_ff <= step_beat(beat_ff);
          if (is_last_beat(beat_ff))
            state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  pbsc_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clock_i     (clock_i),
    .srst_i      (srst_i),
    .in_valid_i  (wr_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({beat_addr, dq_s_ff}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (drain_ready),
    .out_data_o  (fifo_out_data)
  );

  // array is plain flip-flops with no reset, so it is fully static
  always @(posedge clock_i) begin
    if (fifo_out_valid & drain_ready)
      mem_ff[fifo_out_data[FW-1:DATA_W]] <= fifo_out_data[DATA_W-1:0];
  end

  // one cycle late, so a producer near full must keep a word of margin
  always @(posedge clock_i) begin
    if (srst_i)
      write_buf_ready_o <= 1'b0;
    else
      write_buf_ready_o <= fifo_in_ready;
  end

  // read pipe: array stage then output stage, words back to back
  always @(posedge clock_i) begin
    if (srst_i) begin
      rd_vld_ff  <= 1'b0;
      rd_data_ff <= {DATA_W{1'b0}};
    end else begin
      rd_vld_ff <= rd_issue;
      if (rd_issue)
        rd_data_ff <= mem_ff[beat_addr];
    end
  end

  // strobes launch with their word and flip once per word; the half-cycle
  // centring is left to the pad timing since there is only one clock here
  always @(posedge clock_i) begin
    if (srst_i) begin
      dq_o                    <= {DATA_W{1'b0}};
      dq_oe_o                 <= 1'b0;
      lane_a_data_strobe_o    <= 1'b0;
      lane_a_data_strobe_oe_o <= 1'b0;
      lane_b_data_strobe_o    <= 1'b0;
      lane_b_data_strobe_oe_o <= 1'b0;
    end else begin
      dq_oe_o                 <= rd_vld_ff;
      lane_a_data_strobe_oe_o <= rd_vld_ff;
      lane_b_data_strobe_oe_o <= rd_vld_ff;
      if (rd_vld_ff) begin
        dq_o                 <= rd_data_ff;
        lane_a_data_strobe_o <= ~lane_a_data_strobe_o;
        lane_b_data_strobe_o <= ~lane_b_data_strobe_o;
      end else begin
        lane_a_data_strobe_o <= 1'b0;
        lane_b_data_strobe_o <= 1'b0;
      end
    end
  end
endmodule // pbsc_sram_ctrl

// ---- verif/pbsc_ctrl_properties.sv ----
// port assertions for the pipelined burst sram control block
`timescale 1ns/1ps
module pbsc_ctrl_props (
  // clock and reset
  input wire clock_i,
  input wire srst_i,
  // bus pins
  input wire reset_n_i,
  input wire burst_start_strobe_n_i,
  input wire chip_enable_n_i,
  input wire write_n_i,
  // watched outputs
  input wire dq_oe_o,
  input wire lane_a_data_strobe_o,
  input wire lane_a_data_strobe_oe_o,
  input wire lane_b_data_strobe_o,
  input wire lane_b_data_strobe_oe_o,
  input wire init_done_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  wire go = !burst_start_strobe_n_i && !chip_enable_n_i && init_done_o;
  property p_rd_win;
    go && write_n_i |-> ##[4:8] dq_oe_o [*4] ##1 !dq_oe_o;
  endproperty
  a_rd_win: assert property (p_rd_win) else $error("read window");
  property p_wr_quiet;
    go && !write_n_i |-> ##2 !dq_oe_o [*6];
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("write drove");
  property p_toggle;
    dq_oe_o && $past(dq_oe_o) |->
      lane_a_data_strobe_o != $past(lane_a_data_strobe_o);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");
  property p_first;
    $rose(dq_oe_o) |-> lane_a_data_strobe_o;
  endproperty
  a_first: assert property (p_first) else $error("first strobe");
  property p_pair;
    lane_b_data_strobe_o == lane_a_data_strobe_o &&
      lane_a_data_strobe_oe_o == dq_oe_o && lane_b_data_strobe_oe_o == dq_oe_o;
  endproperty
  a_pair: assert property (p_pair) else $error("lane pair");
  property p_release;
    $fell(dq_oe_o) |-> $past(dq_oe_o, 4) && !$past(dq_oe_o, 5);
  endproperty
  a_release: assert property (p_release) else $error("release");
  property p_init;
    $rose(reset_n_i) |-> !init_done_o [*8] ##[1:6] init_done_o;
  endproperty
  a_init: assert property (p_init) else $error("init wait");
  property p_clear;
    !reset_n_i |-> ##3 !init_done_o;
  endproperty
  a_clear: assert property (p_clear) else $error("init clear");
endmodule // pbsc_ctrl_props
bind pbsc_sram_ctrl pbsc_ctrl_props i_props (.clock_i, .srst_i, .reset_n_i,
  .burst_start_strobe_n_i, .chip_enable_n_i, .write_n_i, .dq_oe_o,
  .lane_a_data_strobe_o, .lane_a_data_strobe_oe_o, .lane_b_data_strobe_o,
  .lane_b_data_strobe_oe_o, .init_done_o);

// ---- verif/pbsc_host_model.sv ----
// cache controller model driving the burst sram bus pins
`timescale 1ns/1ps
module pbsc_host_model #(
  parameter AW = 6,
  parameter DW = 36
) (
  // clock and read return
  input  wire          clock_i,
  input  wire          dq_oe_i,
  input  wire [DW-1:0] dq_i,
  // bus pins
  output reg           reset_n_o = 1'b0,
  output reg           ads_n_o   = 1'b1,
  output reg           ce_n_o    = 1'b1,
  output reg           we_n_o    = 1'b1,
  output reg  [AW-1:0] addr_o    = '0,
  output reg  [DW-1:0] dq_o      = '0
);
  // test port is not brought out, no test pins to park
  reg [DW-1:0] rd_q[$];
  always @(posedge clock_i) if (dq_oe_i) rd_q.push_back(dq_i);
  task burst(input wr, input [AW-1:0] a, input [4*DW-1:0] d,
             input [2:0] nb);
    integer k;
    begin
      @(negedge clock_i);
      ads_n_o = 1'b0;
      ce_n_o = 1'b0;
      we_n_o = !wr;
      addr_o = a;
      for (k = 0; k < 4; k = k + 1) begin
        @(negedge clock_i);
        ads_n_o = 1'b1;
        addr_o = '0;
        if (wr) begin
          dq_o = d[k*DW +: DW];
          we_n_o = (k >= 4 - nb);
        end
      end
      @(negedge clock_i);
      ce_n_o = 1'b1;
      we_n_o = 1'b1;
      dq_o = ~dq_o; // released bus must not echo stale data
      repeat (12) @(negedge clock_i);
    end
  endtask
endmodule // pbsc_host_model

// ---- verif/tb.sv ----
// self-checking testbench for the burst sram control block
`timescale 1ns/1ps
module tb;
  localparam DW = 36;
  reg           clock_i = 1'b0;
  reg           srst_i  = 1'b1;
  reg           run     = 1'b1;
  wire          rst_n, ads_n, ce_n, we_n, oe, idone, wbr;
  wire [5:0]    addr;
  wire [DW-1:0] dw, dr;
  integer       err_count = 0;
  integer       checks_done = 0;
  reg  [DW-1:0] mem [0:63];
  always #4 clock_i = clock_i ^ run;
  pbsc_sram_ctrl #(.ADDR_W(6)) i_dut (.clock_i(clock_i), .srst_i(srst_i),
    .reset_n_i(rst_n), .burst_start_strobe_n_i(ads_n),
    .chip_enable_n_i(ce_n), .write_n_i(we_n), .sync_address_in_i(addr),
    .dq_i(dw), .dq_o(dr), .dq_oe_o(oe), .lane_a_data_strobe_o(),
    .lane_a_data_strobe_oe_o(), .lane_b_data_strobe_o(),
    .lane_b_data_strobe_oe_o(), .init_done_o(idone),
    .write_buf_ready_o(wbr));
  pbsc_host_model i_host (.clock_i(clock_i), .dq_oe_i(oe), .dq_i(dr),
    .reset_n_o(rst_n), .ads_n_o(ads_n), .ce_n_o(ce_n), .we_n_o(we_n),
    .addr_o(addr), .dq_o(dw));
  task check(input string name, input [DW-1:0] exp, input [DW-1:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("mismatch %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  function [DW-1:0] word(input [7:0] t, input integer k);
    word = {t, 24'hC3C3C3, k[3:0]};
  endfunction
  task wr(input [5:0] a, input [7:0] t, input integer nb);
    integer k;
    reg [4*DW-1:0] d;
    begin
      for (k = 0; k < 4; k = k + 1)
        d[k*DW +: DW] = word(t, k);
      i_host.burst(1'b1, a, d, nb[2:0]);
      for (k = 0; k < 4 - nb; k = k + 1)
        mem[{a[5:2], a[1:0] + k[1:0]}] = word(t, k);
    end
  endtask
  task rd(input [5:0] a);
    integer k;
    begin
      i_host.rd_q.delete();
      i_host.burst(1'b0, a, '0, 3'h0);
      check("rd_count", 36'h4, i_host.rd_q.size());
      for (k = 0; k < 4; k = k + 1)
        check("rd_word", mem[{a[5:2], a[1:0] + k[1:0]}], i_host.rd_q[k]);
    end
  endtask
  task t_init;
    begin
      check("init_low", 36'h0, idone);
      i_host.reset_n_o = 1'b1;
      i_host.rd_q.delete();
      i_host.burst(1'b0, 6'h00, '0, 3'h0);
      check("early_rd", 36'h0, i_host.rd_q.size());
      check("init_high", 36'h1, idone);
      check("buf_ready", 36'h1, wbr);
      $display("t_init done");
    end
  endtask
  task t_wrap;
    begin
      wr(6'h05, 8'h11, 0);
      rd(6'h04);
      $display("t_wrap done");
    end
  endtask
  task t_block;
    integer nb;
    begin
      for (nb = 1; nb < 4; nb = nb + 1) begin
        wr(6'(nb * 8), 8'h20, 0);
        wr(6'(nb * 8), 8'h40, nb);
        rd(6'(nb * 8));
      end
      $display("t_block done");
    end
  endtask
  task t_stop;
    begin
      wr(6'h30, 8'h5A, 0);
      @(negedge clock_i);
      run = 1'b0;
      #402;
      run = 1'b1;
      repeat (2) @(negedge clock_i);
      rd(6'h30);
      $display("t_stop done");
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(negedge clock_i);
    srst_i = 1'b0;
    t_init;
    t_wrap;
    t_block;
    t_stop;
    report_and_stop;
  end
  // about 300 cycles expected, so ten times that is a hang
  initial begin
    #24000;
    err_count = err_count + 1;
    report_and_stop;
  end
endmodule // tb
